//--- hdl/pbc_mux.sv
// port b bits 0-7 and port c bits 0-5 alternate function multiplexer
//
// Functional notes
// - b0: port bit, or timer2 count input
// - timer2 counts pin only when counter-selected
// - b1: port bit, or timer2 capture/reload input
// - b2: port bit, or serial1 receive input
// - b3: port bit, or serial1 clock/transmit output
// - b4: irq4 on rising edge
// - b5: irq5 on falling edge
// - b6: irq6 on rising edge
// - b7: port bit, or timer2 overflow output
// - overflow output high exactly one cycle
// - c0: port bit, or serial0 receive input
// - c1: port bit, or serial0 clock/transmit output
// - c2: irq0 active low, edge or level
// - c3: irq1 active low, edge or level
// - c4: timer0 count input when counter-selected
// - c5: timer1 count input when counter-selected
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
module pbc_mux
   import pbc_pkg::*;
(
   // clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // axi4-lite write address
   input  wire logic [AW-1:0]        s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   // axi4-lite write data
   input  wire logic [DW-1:0]        s_axi_wdata,
   input  wire logic [DW/8-1:0]      s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // axi4-lite read
   input  wire logic [AW-1:0]        s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [DW-1:0]             s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // pins
   input  wire logic [PB_W-1:0]      portb_in,
   output pbc_pkg::pbc_pin_drv_t     portb_drv,
   input  wire logic [PC_W-1:0]      portc_in,
   output pbc_pkg::pbc_pin_drv_t     portc_drv,
   // on-chip peripherals
   input  pbc_pkg::pbc_periph_out_t  periph_out,
   output pbc_pkg::pbc_periph_in_t   periph_in,
   // interrupts
   output logic                      irq
);
   import pbc_pkg::*;

   logic [PB_W-1:0]   port_b_altfunc_config_reg;
   logic [PC_W-1:0]   port_c_altfunc_config_reg;
   logic [PB_W-1:0]   b_out_reg;
   logic [PB_W-1:0]   b_oe_reg;
   logic [PC_W-1:0]   c_out_reg;
   logic [PC_W-1:0]   c_oe_reg;
   logic [CTRL_W-1:0] ctrl_reg;
   logic [IRQ_W-1:0]  irq_st_reg;
   logic [IRQ_W-1:0]  irq_msk_reg;
   logic [IRQ_W-1:0]  irq_set;
   logic [PB_W-1:0]   b_s1_reg;
   logic [PB_W-1:0]   b_s2_reg;
   logic [PB_W-1:0]   b_d_reg;
   logic [PC_W-1:0]   c_s1_reg;
   logic [PC_W-1:0]   c_s2_reg;
   logic [PC_W-1:0]   c_d_reg;
   logic [AW-1:0]     awaddr_reg;
   logic [DW-1:0]     wdata_reg;
   logic [DW/8-1:0]   wstrb_reg;
   logic              aw_full_reg;
   logic              w_full_reg;
   logic              do_write;
   logic [DW-1:0]     wmask;
   logic [DW-1:0]     rd_word;
   logic              rd_hit;
   logic              wr_hit;

   // two-flop synchronisers on every pin input; third stage for edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         b_s1_reg <= '0;
         b_s2_reg <= '0;
         b_d_reg  <= '0;
         c_s1_reg <= '1;
         c_s2_reg <= '1;
         c_d_reg  <= '1;
      end else begin
         b_s1_reg <= portb_in;
         b_s2_reg <= b_s1_reg;
         b_d_reg  <= b_s2_reg;
         c_s1_reg <= portc_in;
         c_s2_reg <= c_s1_reg;
         c_d_reg  <= c_s2_reg;
      end
   end

   // ---------------- axi4-lite write ----------------
   // address and data are latched separately, in either order
   assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg   <= 1'b0;
         w_full_reg    <= 1'b0;
         awaddr_reg    <= '0;
         wdata_reg     <= ZERO_WORD;
         wstrb_reg     <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_full_reg && !s_axi_awready && !do_write;
         s_axi_wready  <= !w_full_reg && !s_axi_wready && !do_write;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      wr_hit = 1'b1;
      case (awaddr_reg)
         OFS_B_CFG, OFS_C_CFG, OFS_B_OUT, OFS_B_OE, OFS_C_OUT,
         OFS_C_OE, OFS_PIN_IN, OFS_CTRL, OFS_IRQ_ST,
         OFS_IRQ_MSK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // byte enables expand to a bit mask
   generate
      for (genvar i = 0; i < DW/8; i++) begin : g_strb
         assign wmask[8*i +: 8] = {8{wstrb_reg[i]}};
      end
   endgenerate

   // configuration registers; all selects clear on reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_b_altfunc_config_reg <= '0;
         port_c_altfunc_config_reg <= '0;
         b_out_reg   <= '0;
         b_oe_reg    <= '0;
         c_out_reg   <= '0;
         c_oe_reg    <= '0;
         ctrl_reg    <= '0;
         irq_msk_reg <= '0;
      end else if (do_write) begin
         case (awaddr_reg)
            OFS_B_CFG: port_b_altfunc_config_reg <=
               (port_b_altfunc_config_reg & ~wmask[PB_W-1:0])
               | (wdata_reg[PB_W-1:0] & wmask[PB_W-1:0]);
            OFS_C_CFG: port_c_altfunc_config_reg <=
               (port_c_altfunc_config_reg & ~wmask[PC_W-1:0])
               | (wdata_reg[PC_W-1:0] & wmask[PC_W-1:0]);
            OFS_B_OUT: b_out_reg <= (b_out_reg & ~wmask[PB_W-1:0])
               | (wdata_reg[PB_W-1:0] & wmask[PB_W-1:0]);
            OFS_B_OE: b_oe_reg <= (b_oe_reg & ~wmask[PB_W-1:0])
               | (wdata_reg[PB_W-1:0] & wmask[PB_W-1:0]);
            OFS_C_OUT: c_out_reg <= (c_out_reg & ~wmask[PC_W-1:0])
               | (wdata_reg[PC_W-1:0] & wmask[PC_W-1:0]);
            OFS_C_OE: c_oe_reg <= (c_oe_reg & ~wmask[PC_W-1:0])
               | (wdata_reg[PC_W-1:0] & wmask[PC_W-1:0]);
            OFS_CTRL: ctrl_reg <= (ctrl_reg & ~wmask[CTRL_W-1:0])
               | (wdata_reg[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
            OFS_IRQ_MSK: irq_msk_reg <= (irq_msk_reg & ~wmask[IRQ_W-1:0])
               | (wdata_reg[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
            default: ;
         endcase
      end
   end

   // ---------------- axi4-lite read ----------------
   always_comb begin
      rd_word = ZERO_WORD;
      rd_hit  = 1'b1;
      case (s_axi_araddr)
         OFS_B_CFG:   rd_word[PB_W-1:0]   = port_b_altfunc_config_reg;
         OFS_C_CFG:   rd_word[PC_W-1:0]   = port_c_altfunc_config_reg;
         OFS_B_OUT:   rd_word[PB_W-1:0]   = b_out_reg;
         OFS_B_OE:    rd_word[PB_W-1:0]   = b_oe_reg;
         OFS_C_OUT:   rd_word[PC_W-1:0]   = c_out_reg;
         OFS_C_OE:    rd_word[PC_W-1:0]   = c_oe_reg;
         OFS_PIN_IN:  rd_word[PB_W+PC_W-1:0] = {c_s2_reg, b_s2_reg};
         OFS_CTRL:    rd_word[CTRL_W-1:0] = ctrl_reg;
         OFS_IRQ_ST:  rd_word[IRQ_W-1:0]  = irq_st_reg;
         OFS_IRQ_MSK: rd_word[IRQ_W-1:0]  = irq_msk_reg;
         default:     rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= ZERO_WORD;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ---------------- external interrupt detection ----------------
   // an unselected pin raises nothing
   always_comb begin
      irq_set = '0;
      irq_set[IRQ_EXT4] = port_b_altfunc_config_reg[PB_IRQ4]
         && b_s2_reg[PB_IRQ4] && !b_d_reg[PB_IRQ4];
      irq_set[IRQ_EXT5] = port_b_altfunc_config_reg[PB_IRQ5]
         && !b_s2_reg[PB_IRQ5] && b_d_reg[PB_IRQ5];
      irq_set[IRQ_EXT6] = port_b_altfunc_config_reg[PB_IRQ6]
         && b_s2_reg[PB_IRQ6] && !b_d_reg[PB_IRQ6];
      // level mode keeps setting while the pin is held low
      irq_set[IRQ_EXT0] = port_c_altfunc_config_reg[PC_IRQ0]
         && !c_s2_reg[PC_IRQ0]
         && (!ctrl_reg[CTRL_IRQ0_EDGE] || c_d_reg[PC_IRQ0]);
      irq_set[IRQ_EXT1] = port_c_altfunc_config_reg[PC_IRQ1]
         && !c_s2_reg[PC_IRQ1]
         && (!ctrl_reg[CTRL_IRQ1_EDGE] || c_d_reg[PC_IRQ1]);
   end

   // sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_st_reg <= '0;
      end else if (do_write && awaddr_reg == OFS_IRQ_ST) begin
         irq_st_reg <= (irq_st_reg & ~(wdata_reg[IRQ_W-1:0]
            & wmask[IRQ_W-1:0])) | irq_set;
      end else begin
         irq_st_reg <= irq_st_reg | irq_set;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_st_reg & irq_msk_reg);
      end
   end

   // ---------------- peripheral inputs ----------------
   // deselected or timer-mode inputs are held inactive
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         periph_in <= '0;
      end else begin
         periph_in.t2_count <= port_b_altfunc_config_reg[PB_T2]
            && ctrl_reg[CTRL_T2_CNT] && b_s2_reg[PB_T2];
         periph_in.t2_capture <= port_b_altfunc_config_reg[PB_T2EXT]
            && b_s2_reg[PB_T2EXT];
         // idle serial line is high
         periph_in.ser1_rx <= !port_b_altfunc_config_reg[PB_RX1]
            || b_s2_reg[PB_RX1];
         periph_in.ser0_rx <= !port_c_altfunc_config_reg[PC_RX0]
            || c_s2_reg[PC_RX0];
         periph_in.t0_count <= port_c_altfunc_config_reg[PC_T0]
            && ctrl_reg[CTRL_T0_CNT] && c_s2_reg[PC_T0];
         periph_in.t1_count <= port_c_altfunc_config_reg[PC_T1]
            && ctrl_reg[CTRL_T1_CNT] && c_s2_reg[PC_T1];
      end
   end

   // ---------------- pin drivers ----------------
   // input-only alternates leave the pin undriven
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         portb_drv <= '0;
         portc_drv <= '0;
      end else begin
         portb_drv.out <= b_out_reg;
         portb_drv.oe  <= b_oe_reg & ~port_b_altfunc_config_reg;
         portc_drv.out <= '0;
         portc_drv.oe  <= '0;
         portc_drv.out[PC_W-1:0] <= c_out_reg;
         portc_drv.oe[PC_W-1:0]  <= c_oe_reg
            & ~port_c_altfunc_config_reg;
         if (port_b_altfunc_config_reg[PB_TX1]) begin
            portb_drv.out[PB_TX1] <= periph_out.ser1_tx;
            portb_drv.oe[PB_TX1]  <= 1'b1;
         end
         // peripheral gives a one-cycle pulse; passed through unstretched
         if (port_b_altfunc_config_reg[PB_T2OV]) begin
            portb_drv.out[PB_T2OV] <= periph_out.t2_overflow;
            portb_drv.oe[PB_T2OV]  <= 1'b1;
         end
         if (port_c_altfunc_config_reg[PC_TX0]) begin
            portc_drv.out[PC_TX0] <= periph_out.ser0_tx;
            portc_drv.oe[PC_TX0]  <= 1'b1;
         end
      end
   end

endmodule

//--- hdl/pbc_pkg.sv
// package: register map, field layout and carrier types of the port b/c mux
package pbc_pkg;

   localparam int unsigned AW = 8;
   localparam int unsigned DW = 32;

   // register byte offsets
   localparam logic [AW-1:0] OFS_B_CFG   = 8'h00;
   localparam logic [AW-1:0] OFS_C_CFG   = 8'h04;
   localparam logic [AW-1:0] OFS_B_OUT   = 8'h08;
   localparam logic [AW-1:0] OFS_B_OE    = 8'h0C;
   localparam logic [AW-1:0] OFS_C_OUT   = 8'h10;
   localparam logic [AW-1:0] OFS_C_OE    = 8'h14;
   localparam logic [AW-1:0] OFS_PIN_IN  = 8'h18;
   localparam logic [AW-1:0] OFS_CTRL    = 8'h1C;
   localparam logic [AW-1:0] OFS_IRQ_ST  = 8'h20;
   localparam logic [AW-1:0] OFS_IRQ_MSK = 8'h24;

   // field positions of the control register
   localparam int unsigned CTRL_T0_CNT = 0;
   localparam int unsigned CTRL_T1_CNT = 1;
   localparam int unsigned CTRL_T2_CNT = 2;
   localparam int unsigned CTRL_IRQ0_EDGE = 3;
   localparam int unsigned CTRL_IRQ1_EDGE = 4;
   localparam int unsigned CTRL_W = 5;

   // irq status bit positions
   localparam int unsigned IRQ_EXT0 = 0;
   localparam int unsigned IRQ_EXT1 = 1;
   localparam int unsigned IRQ_EXT4 = 2;
   localparam int unsigned IRQ_EXT5 = 3;
   localparam int unsigned IRQ_EXT6 = 4;
   localparam int unsigned IRQ_W = 5;

   // port bit positions
   localparam int unsigned PB_T2 = 0;
   localparam int unsigned PB_T2EXT = 1;
   localparam int unsigned PB_RX1 = 2;
   localparam int unsigned PB_TX1 = 3;
   localparam int unsigned PB_IRQ4 = 4;
   localparam int unsigned PB_IRQ5 = 5;
   localparam int unsigned PB_IRQ6 = 6;
   localparam int unsigned PB_T2OV = 7;
   localparam int unsigned PC_RX0 = 0;
   localparam int unsigned PC_TX0 = 1;
   localparam int unsigned PC_IRQ0 = 2;
   localparam int unsigned PC_IRQ1 = 3;
   localparam int unsigned PC_T0 = 4;
   localparam int unsigned PC_T1 = 5;
   localparam int unsigned PB_W = 8;
   localparam int unsigned PC_W = 6;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [DW-1:0] ZERO_WORD = 32'h0000_0000;

   // signals toward the on-chip peripherals
   typedef struct packed {
      logic t0_count;
      logic t1_count;
      logic t2_count;
      logic t2_capture;
      logic ser0_rx;
      logic ser1_rx;
   } pbc_periph_in_t;

   // signals from the on-chip peripherals
   typedef struct packed {
      logic ser0_tx;
      logic ser1_tx;
      logic t2_overflow;
   } pbc_periph_out_t;

   // pin drive for one port
   typedef struct packed {
      logic [PB_W-1:0] out;
      logic [PB_W-1:0] oe;
   } pbc_pin_drv_t;

endpackage

//--- testbench/pbc_mux_assertions.sv
// checker: port-level properties of the port b/c mux
module pbc_mux_assertions
   import pbc_pkg::*;
(
   // clock and reset
   input wire logic                aclk,
   input wire logic                aresetn,
   // bus answers
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_bready,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_rready,
   input wire logic [DW-1:0]       s_axi_rdata,
   // pins and peripherals
   input wire logic [PB_W-1:0]     portb_in,
   input wire logic [PC_W-1:0]     portc_in,
   input pbc_pkg::pbc_pin_drv_t    portb_drv,
   input pbc_pkg::pbc_pin_drv_t    portc_drv,
   input pbc_pkg::pbc_periph_in_t  periph_in
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // a peripheral input only ever shows the pin seen three edges back
   property p_t2_count;
      periph_in.t2_count && $past(aresetn) |-> $past(portb_in[PB_T2], 3);
   endproperty
   a_t2_count: assert property (p_t2_count)
      else $error("timer2 count without pin");
   property p_t2_cap;
      periph_in.t2_capture && $past(aresetn) |-> $past(portb_in[PB_T2EXT], 3);
   endproperty
   a_t2_cap: assert property (p_t2_cap)
      else $error("capture without pin");
   // deselected receive lines idle high, so a low must come from the pin
   property p_ser1_rx;
      !periph_in.ser1_rx && $past(aresetn) |-> !$past(portb_in[PB_RX1], 3);
   endproperty
   a_ser1_rx: assert property (p_ser1_rx)
      else $error("serial1 receive low without pin");
   property p_ser0_rx;
      !periph_in.ser0_rx && $past(aresetn) |-> !$past(portc_in[PC_RX0], 3);
   endproperty
   a_ser0_rx: assert property (p_ser0_rx)
      else $error("serial0 receive low without pin");
   property p_t0_count;
      periph_in.t0_count && $past(aresetn) |-> $past(portc_in[PC_T0], 3);
   endproperty
   a_t0_count: assert property (p_t0_count)
      else $error("timer0 count without pin");
   property p_t1_count;
      periph_in.t1_count && $past(aresetn) |-> $past(portc_in[PC_T1], 3);
   endproperty
   a_t1_count: assert property (p_t1_count)
      else $error("timer1 count without pin");
   property p_reset_idle;
      disable iff (1'b0)
      !aresetn |=> {portb_drv, portc_drv, periph_in.t2_count} == '0;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("pins driven after reset");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write answer dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read answer dropped");
endmodule

//--- testbench/pbc_pins_model.sv
// board model: pin levels from mux drive, board sources and pull-ups
module pbc_pins_model
   import pbc_pkg::*;
(
   // mux pin drive
   input pbc_pkg::pbc_pin_drv_t  portb_drv,
   input pbc_pkg::pbc_pin_drv_t  portc_drv,
   // board sources, released while ext_en is low
   input wire logic [PB_W-1:0]   ext_b,
   input wire logic [PC_W-1:0]   ext_c,
   input wire logic              ext_en,
   // resolved pin levels
   output logic [PB_W-1:0]       portb_in,
   output logic [PC_W-1:0]       portc_in
);
   logic [PB_W-1:0] src_b;
   logic [PC_W-1:0] src_c;
   // released lines go high through pull-ups, never a stale level
   assign src_b = ext_en ? ext_b : 8'hFF;
   assign src_c = ext_en ? ext_c : 6'h3F;
   assign portb_in = (portb_drv.oe & portb_drv.out) | (~portb_drv.oe & src_b);
   assign portc_in = (portc_drv.oe[5:0] & portc_drv.out[5:0])
                   | (~portc_drv.oe[5:0] & src_c);
endmodule

//--- testbench/pbc_mux_tb.sv
// testbench: drives the port b/c mux over the bus and its pins
module pbc_mux_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pbc_pkg::*;
   logic [AW-1:0]   s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [DW-1:0]   s_axi_wdata = '0, s_axi_rdata, d;
   logic [3:0]      s_axi_wstrb = 4'hF;
   logic [1:0]      s_axi_bresp, s_axi_rresp, r;
   logic            s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic            s_axi_arvalid = 0, s_axi_rready = 0, ext_en = 1;
   logic            s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic            s_axi_arready, s_axi_rvalid, irq, aclk, aresetn = 0;
   logic [PB_W-1:0] portb_in, ext_b = 8'h00;
   logic [PC_W-1:0] portc_in, ext_c = 6'h3F;
   pbc_pin_drv_t    portb_drv, portc_drv;
   pbc_periph_out_t periph_out = '0;
   pbc_periph_in_t  periph_in;
   int              miscompares = 0, samples_checked = 0, cycles = 0;

   pbc_mux dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .portb_in, .portb_drv,
      .portc_in, .portc_drv, .periph_out, .periph_in, .irq);
   pbc_pins_model u_pins (.portb_drv, .portc_drv, .ext_b, .ext_c, .ext_en,
      .portb_in, .portc_in);

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic report_and_stop;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares++;
         report_and_stop;
      end
   end

   task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask

   // answers are taken a cycle late so the slave must hold them
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) break;
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v,
                     output logic [1:0] rr);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      v = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic pins(input logic [7:0] b, input logic [5:0] c);
      @(posedge aclk);
      ext_b <= b;
      ext_c <= c;
      cyc(5);
   endtask

   task automatic t_reset;
      rd(OFS_B_CFG, d, r);
      chk(d, ZERO_WORD);
      rd(OFS_C_CFG, d, r);
      chk(d, ZERO_WORD);
      chk({portb_drv, portc_drv}, ZERO_WORD);
      rd(8'h40, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      // response code stays on the bus after the handshake
      wr(8'h40, ZERO_WORD);
      chk(32'(s_axi_bresp), 32'(RESP_SLVERR));
      wr(OFS_B_OUT, ZERO_WORD);
      chk(32'(s_axi_bresp), 32'(RESP_OKAY));
   endtask

   task automatic t_inputs;
      wr(OFS_B_CFG, 32'h0000_00FF);
      wr(OFS_C_CFG, 32'h0000_003F);
      wr(OFS_CTRL, 32'h0000_0007);
      pins(8'h05, 6'h10);
      chk(32'(periph_in), 32'h29);
      pins(8'h02, 6'h21);
      chk(32'(periph_in), 32'h16);
      chk(32'({portb_drv.oe, portc_drv.oe}), 32'h8802);
      wr(OFS_CTRL, ZERO_WORD);
      pins(8'hFF, 6'h3F);
      chk(32'(periph_in), 32'h07);
      wr(OFS_CTRL, 32'h0000_0007);
      wr(OFS_B_CFG, ZERO_WORD);
      wr(OFS_C_CFG, ZERO_WORD);
      cyc(3);
      chk(32'(periph_in), 32'h03);
   endtask

   task automatic t_outputs;
      wr(OFS_B_CFG, 32'h0000_0088);
      wr(OFS_C_CFG, 32'h0000_0002);
      for (int k = 0; k < 2; k++) begin
         @(posedge aclk);
         periph_out <= k ? 3'b010 : 3'b100;
         cyc(2);
         chk(32'({portb_drv.out[PB_TX1], portc_drv.out[PC_TX0]}),
             k ? 32'h2 : 32'h1);
      end
      chk(32'(portb_drv.out[PB_T2OV]), ZERO_WORD);
      @(posedge aclk);
      periph_out <= 3'b001;
      @(posedge aclk);
      periph_out <= 3'b000;
      #1;
      chk(32'(portb_drv.out[PB_T2OV]), 32'h1);
      cyc(1);
      chk(32'(portb_drv.out[PB_T2OV]), ZERO_WORD);
   endtask

   task automatic t_gpio;
      wr(OFS_B_CFG, ZERO_WORD);
      wr(OFS_C_CFG, ZERO_WORD);
      wr(OFS_B_OUT, 32'h0000_00A5);
      wr(OFS_B_OE, 32'h0000_00F0);
      wr(OFS_C_OUT, 32'h0000_002A);
      wr(OFS_C_OE, 32'h0000_003F);
      @(posedge aclk);
      ext_en <= 1'b0;
      cyc(5);
      rd(OFS_PIN_IN, d, r);
      chk(d, 32'h0000_2AAF);
      @(posedge aclk);
      ext_en <= 1'b1;
   endtask

   task automatic t_irq;
      logic [7:0] sb [6] = '{8'h30, 8'h10, 8'h50, 8'h60, 8'h60, 8'h60};
      logic [5:0] sc [6] = '{6'h0C, 6'h0C, 6'h0C, 6'h0C, 6'h08, 6'h00};
      logic [7:0] se [6] = '{8'h04, 8'h0C, 8'h1C, 8'h1C, 8'h1D, 8'h1F};
      pins(8'h20, 6'h0C);
      wr(OFS_B_CFG, 32'h0000_0070);
      wr(OFS_C_CFG, 32'h0000_000C);
      wr(OFS_CTRL, 32'h0000_0008);
      wr(OFS_IRQ_MSK, 32'h0000_001F);
      wr(OFS_IRQ_ST, 32'h0000_001F);
      rd(OFS_IRQ_ST, d, r);
      chk(d, ZERO_WORD);
      chk(32'(irq), ZERO_WORD);
      for (int k = 0; k < 6; k++) begin
         pins(sb[k], sc[k]);
         rd(OFS_IRQ_ST, d, r);
         chk(d, 32'(se[k]));
      end
      chk(32'(irq), 32'h1);
      wr(OFS_IRQ_ST, 32'h0000_001F);
      rd(OFS_IRQ_ST, d, r);
      chk(d, 32'h0000_0002);
      wr(OFS_CTRL, 32'h0000_0010);
      wr(OFS_IRQ_ST, 32'h0000_001F);
      rd(OFS_IRQ_ST, d, r);
      chk(d, 32'h0000_0001);
      wr(OFS_IRQ_MSK, 32'h0000_0002);
      cyc(2);
      chk(32'(irq), ZERO_WORD);
   endtask

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_inputs;
      t_outputs;
      t_gpio;
      t_irq;
      report_and_stop;
   end
endmodule

bind pbc_mux pbc_mux_assertions u_chk (.aclk, .aresetn, .s_axi_bvalid,
   .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .portb_in,
   .portc_in, .portb_drv, .portc_drv, .periph_in);
